// file: rtl/gtil_global_config.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - Three bytes hold eight 3-bit source codes.
// - Highest-priority pending source wins per channel.
// - Code zero means nothing pending.
// - Code 1 for receive-ready or line errors.
// - Code 2 for receive data time-out.
// - Code 3 for transmit-ready.
// - Code 4 for modem delta or character detect.
// - Code 7 timer only in channel 0.
// - Timer counts crystal or external pin clock.
// - Terminal count from high and low bytes.
// - Count bytes read back programmed value only.
// - Count bytes reset to zero.
// - Commands self-clear; upper bits reserved.
// - Command read shows pending flag, clears it.
// - Codes 1 and 2 enable/disable interrupt.
// - Codes 3 and 4 select one-shot/periodic.
// - Codes 5 and 6 select clock source.
// - Codes 9, 10, 11 start, stop, reset.
// - Reset: disabled, periodic, crystal, stopped.
// - One-shot times out once; periodic repeats.
// - Select bits give 16X, 8X or 4X.
// - Summary bit set while channel requests service.
module gtil_global_config
#(
  parameter int NCH = gtil_pkg::NUM_CH
)
(
  // Clock and reset.
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  // Register port.
  input  wire logic [7:0]            i_addr,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  input  wire logic [7:0]            i_wdata,
  output logic      [7:0]            o_rdata,
  // Timer clock sources.
  input  wire logic                  i_xtal_tick,
  input  wire logic                  i_timer_ext_clock_pin,
  // Per-channel pending sources from the UART cores.
  input  wire logic [NCH-1:0]        i_receive_ready_int,
  input  wire logic [NCH-1:0]        i_line_status_int,
  input  wire logic [NCH-1:0]        i_rx_timeout_int,
  input  wire logic [NCH-1:0]        i_transmit_ready_int,
  input  wire logic [NCH-1:0]        i_modem_int,
  // Outputs.
  output logic      [NCH-1:0]        o_channel_summary_flags,
  output logic      [NCH*2-1:0]      o_sample_rate,
  output logic                       o_irq,
  output logic                       o_timer_timeout
);

  typedef logic [gtil_pkg::CODE_W-1:0] gtil_code_t;

  // Priority encoder shared by every channel.
  function automatic gtil_code_t gtil_encode(input logic rx, input logic ls,
                                             input logic to, input logic tx,
                                             input logic md, input logic tm);
    gtil_code_t c;
    c = gtil_pkg::SRC_NONE;
    if (rx || ls)
      c = gtil_pkg::SRC_RX;
    else if (to)
      c = gtil_pkg::SRC_RX_TOUT;
    else if (tx)
      c = gtil_pkg::SRC_TX;
    else if (md)
      c = gtil_pkg::SRC_MODEM;
    else if (tm)
      c = gtil_pkg::SRC_TIMER;
    return c;
  endfunction : gtil_encode

  // Registers.
  logic [7:0]  reload_lo_q;
  logic [7:0]  reload_hi_q;
  logic [7:0]  x8_q;
  logic [7:0]  x4_q;
  logic        int_en_q;
  logic        oneshot_q;
  logic        ext_src_q;
  logic        running_q;
  logic        pending_q;
  logic [15:0] count_q;
  logic        ext_s1_q;
  logic        ext_s2_q;
  logic        ext_s3_q;

  logic [15:0] term_n;
  logic        cmd_wr;
  logic [3:0]  cmd;
  logic        tick;
  logic        timeout;
  logic        stat_rd;
  logic [NCH*3-1:0] codes;

  assign term_n  = {reload_hi_q, reload_lo_q};
  assign cmd_wr  = i_wr && (i_addr == gtil_pkg::ADDR_TMR_CMD);
  assign cmd     = i_wdata[gtil_pkg::CMD_MSB:gtil_pkg::CMD_LSB];
  assign stat_rd = i_rd && (i_addr == gtil_pkg::ADDR_TMR_CMD);

  // External pin synchroniser plus rising-edge detect on the second stage.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end
    else
    begin
      ext_s1_q <= i_timer_ext_clock_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign tick = ext_src_q ? (ext_s2_q && !ext_s3_q) : i_xtal_tick;
  assign timeout = running_q && tick && (count_q == 16'h0001);

  // Count-value and sample-rate registers.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      reload_lo_q <= gtil_pkg::RST_RELOAD;
      reload_hi_q <= gtil_pkg::RST_RELOAD;
      x8_q        <= gtil_pkg::RST_X8;
      x4_q        <= gtil_pkg::RST_X4;
    end
    else if (i_wr)
    begin
      if (i_addr == gtil_pkg::ADDR_RELOAD_LO)
        reload_lo_q <= i_wdata;
      else if (i_addr == gtil_pkg::ADDR_RELOAD_HI)
        reload_hi_q <= i_wdata;
      else if (i_addr == gtil_pkg::ADDR_X8_SEL)
        x8_q <= i_wdata;
      else if (i_addr == gtil_pkg::ADDR_X4_SEL)
        x4_q <= i_wdata;
    end
  end

  // Timer mode bits, driven only by commands; nothing stores the command.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      int_en_q  <= 1'b0;
      oneshot_q <= 1'b0;
      ext_src_q <= 1'b0;
    end
    else if (cmd_wr)
    begin
      case (cmd)
        gtil_pkg::CMD_INT_EN:   int_en_q  <= 1'b1;
        gtil_pkg::CMD_INT_DIS:  int_en_q  <= 1'b0;
        gtil_pkg::CMD_ONESHOT:  oneshot_q <= 1'b1;
        gtil_pkg::CMD_PERIODIC: oneshot_q <= 1'b0;
        gtil_pkg::CMD_SRC_XTAL: ext_src_q <= 1'b0;
        gtil_pkg::CMD_SRC_EXT:  ext_src_q <= 1'b1;
        default:                ;
      endcase
    end
  end

  // Counter: loads N at start, times out after N ticks.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      running_q <= 1'b0;
      count_q   <= 16'h0000;
    end
    else if (cmd_wr && cmd == gtil_pkg::CMD_START)
    begin
      running_q <= 1'b1;
      count_q   <= term_n;
    end
    else if (cmd_wr && cmd == gtil_pkg::CMD_STOP)
      running_q <= 1'b0;
    else if (cmd_wr && cmd == gtil_pkg::CMD_RESET)
    begin
      running_q <= 1'b0;
      count_q   <= term_n;
    end
    else if (running_q && tick)
    begin
      if (count_q == 16'h0001)
      begin
        count_q   <= term_n;
        running_q <= !oneshot_q;
      end
      else
        count_q <= count_q - 16'h0001;
    end
  end

  // Pending flag: a time-out in the clearing cycle still sets it.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      pending_q <= 1'b0;
    else if (timeout)
      pending_q <= 1'b1;
    else if (stat_rd)
      pending_q <= 1'b0;
  end

  // Source codes and summary flags.
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      logic tm;
      assign tm = (g == 0) ? (pending_q && int_en_q) : 1'b0;
      assign codes[g*3 +: 3] = gtil_encode(i_receive_ready_int[g],
                                           i_line_status_int[g],
                                           i_rx_timeout_int[g],
                                           i_transmit_ready_int[g],
                                           i_modem_int[g], tm);
      assign o_channel_summary_flags[g] =
        (codes[g*3 +: 3] != gtil_pkg::SRC_NONE);
      assign o_sample_rate[g*2 +: 2] =
        (x8_q[g] && !x4_q[g]) ? gtil_pkg::GTIL_RATE_8X :
        (x4_q[g] && !x8_q[g]) ? gtil_pkg::GTIL_RATE_4X :
                                gtil_pkg::GTIL_RATE_16X;
    end
  endgenerate

  assign o_irq = |o_channel_summary_flags;
  assign o_timer_timeout = timeout;

  // Read data mux.
  always_comb
  begin
    o_rdata = 8'h00;
    if (i_addr == gtil_pkg::ADDR_SUMMARY)
      o_rdata = o_channel_summary_flags;
    else if (i_addr == gtil_pkg::ADDR_SRC_A)
      o_rdata = codes[7:0];
    else if (i_addr == gtil_pkg::ADDR_SRC_B)
      o_rdata = codes[15:8];
    else if (i_addr == gtil_pkg::ADDR_SRC_C)
      o_rdata = codes[23:16];
    else if (i_addr == gtil_pkg::ADDR_TMR_CMD)
      o_rdata = pending_q ? gtil_pkg::STAT_PENDING
                          : gtil_pkg::STAT_IDLE;
    else if (i_addr == gtil_pkg::ADDR_RELOAD_LO)
      o_rdata = reload_lo_q;
    else if (i_addr == gtil_pkg::ADDR_RELOAD_HI)
      o_rdata = reload_hi_q;
    else if (i_addr == gtil_pkg::ADDR_X8_SEL)
      o_rdata = x8_q;
    else if (i_addr == gtil_pkg::ADDR_X4_SEL)
      o_rdata = x4_q;
  end

endmodule : gtil_global_config

`default_nettype wire

// file: rtl/gtil_pkg.sv
package gtil_pkg;

  // Register addresses on the device's 8-bit address bus.
  localparam logic [7:0] ADDR_SUMMARY   = 8'h80;
  localparam logic [7:0] ADDR_SRC_A     = 8'h81;
  localparam logic [7:0] ADDR_SRC_B     = 8'h82;
  localparam logic [7:0] ADDR_SRC_C     = 8'h83;
  localparam logic [7:0] ADDR_TMR_CMD   = 8'h84;
  localparam logic [7:0] ADDR_SPARE     = 8'h85;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'h86;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'h87;
  localparam logic [7:0] ADDR_X8_SEL    = 8'h88;
  localparam logic [7:0] ADDR_X4_SEL    = 8'h89;

  // Reset values.
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [7:0] RST_X8     = 8'h00;
  localparam logic [7:0] RST_X4     = 8'h00;

  // Command field of the timer command register.
  localparam int CMD_LSB = 0;
  localparam int CMD_MSB = 3;

  localparam logic [3:0] CMD_INT_EN    = 4'h1;
  localparam logic [3:0] CMD_INT_DIS   = 4'h2;
  localparam logic [3:0] CMD_ONESHOT   = 4'h3;
  localparam logic [3:0] CMD_PERIODIC  = 4'h4;
  localparam logic [3:0] CMD_SRC_XTAL  = 4'h5;
  localparam logic [3:0] CMD_SRC_EXT   = 4'h6;
  localparam logic [3:0] CMD_START     = 4'h9;
  localparam logic [3:0] CMD_STOP      = 4'ha;
  localparam logic [3:0] CMD_RESET     = 4'hb;

  localparam logic [7:0] STAT_PENDING = 8'h01;
  localparam logic [7:0] STAT_IDLE    = 8'h00;

  // Per-channel interrupt source codes.
  localparam logic [2:0] SRC_NONE    = 3'h0;
  localparam logic [2:0] SRC_RX      = 3'h1;
  localparam logic [2:0] SRC_RX_TOUT = 3'h2;
  localparam logic [2:0] SRC_TX      = 3'h3;
  localparam logic [2:0] SRC_MODEM   = 3'h4;
  localparam logic [2:0] SRC_TIMER   = 3'h7;

  // Sample-rate encodings.
  typedef enum logic [1:0]
  {
    GTIL_RATE_16X = 2'b00,
    GTIL_RATE_8X  = 2'b01,
    GTIL_RATE_4X  = 2'b10
  } gtil_rate_t;

  localparam int NUM_CH   = 8;
  localparam int CODE_W   = 3;
  localparam int TIMER_W  = 16;

endpackage : gtil_pkg

// file: verif/gtil_tick_model.sv
`timescale 1ns/1ps
`default_nettype none
module gtil_tick_model
(
  // Clock and enables.
  input  wire logic i_clk,
  input  wire logic i_xtal_en,
  input  wire logic i_ext_en,
  // Timer clocks.
  output logic      o_xtal_tick = 1'b0,
  output logic      o_ext_clk = 1'b0
);
  logic [1:0] cnt_q = 2'h0;
  // The pin clock stands low while disabled, as a gated oscillator would.
  always @(posedge i_clk)
  begin
    o_xtal_tick <= i_xtal_en;
    cnt_q <= cnt_q + 2'h1;
    if (!i_ext_en)
      o_ext_clk <= 1'b0;
    else if (cnt_q == 2'h3)
      o_ext_clk <= ~o_ext_clk;
  end
endmodule : gtil_tick_model
`default_nettype wire

// file: verif/gtil_global_config_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gtil_checker
#(
  parameter int NCH = 8
)
(
  // Clock, reset and register port.
  input wire logic           i_clk,
  input wire logic           i_resetn,
  input wire logic [7:0]     i_addr,
  input wire logic           i_rd,
  input wire logic [7:0]     o_rdata,
  // Sources and outputs.
  input wire logic [NCH-1:0] i_receive_ready_int,
  input wire logic [NCH-1:0] o_channel_summary_flags,
  input wire logic [2*NCH-1:0] o_sample_rate,
  input wire logic           o_irq,
  input wire logic           o_timer_timeout
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  sequence s_look;
    i_addr == gtil_pkg::ADDR_TMR_CMD;
  endsequence
  sequence s_clr;
    s_look and (i_rd && !o_timer_timeout);
  endsequence
  property p_irq;
    o_irq == |o_channel_summary_flags;
  endproperty
  a_irq: assert property (p_irq) else $error("irq bad");
  property p_flag;
    (i_receive_ready_int & ~o_channel_summary_flags) == '0;
  endproperty
  a_flag: assert property (p_flag) else $error("flag bad");
  property p_rate;
    (o_sample_rate & (o_sample_rate >> 1) & {NCH{2'b01}}) == '0;
  endproperty
  a_rate: assert property (p_rate) else $error("rate bad");
  property p_stat;
    s_look |-> o_rdata[7:1] == 7'h00;
  endproperty
  a_stat: assert property (p_stat) else $error("stat bad");
  property p_clear;
    s_clr ##1 s_look |-> o_rdata == gtil_pkg::STAT_IDLE;
  endproperty
  a_clear: assert property (p_clear) else $error("no clear");
  property p_set;
    o_timer_timeout ##1 s_look |-> o_rdata == gtil_pkg::STAT_PENDING;
  endproperty
  a_set: assert property (p_set) else $error("no set");
  property p_ch1;
    i_addr == gtil_pkg::ADDR_SRC_A |-> o_rdata[5:3] != 3'h7;
  endproperty
  a_ch1: assert property (p_ch1) else $error("code 7 ch1");
  property p_prio;
    i_receive_ready_int[0] && i_addr == gtil_pkg::ADDR_SRC_A
      |-> o_rdata[2:0] == gtil_pkg::SRC_RX;
  endproperty
  a_prio: assert property (p_prio) else $error("prio bad");
  property p_none;
    !o_channel_summary_flags[0] && i_addr == gtil_pkg::ADDR_SRC_A
      |-> o_rdata[2:0] == gtil_pkg::SRC_NONE;
  endproperty
  a_none: assert property (p_none) else $error("code not 0");
  property p_gap;
    o_timer_timeout |=> !o_timer_timeout;
  endproperty
  a_gap: assert property (p_gap) else $error("gap bad");
endmodule : gtil_checker
bind gtil_global_config gtil_checker #(.NCH(NCH)) chk_u (.i_clk(i_clk),
  .i_resetn(i_resetn), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_receive_ready_int(i_receive_ready_int), .o_irq(o_irq),
  .o_channel_summary_flags(o_channel_summary_flags),
  .o_sample_rate(o_sample_rate), .o_timer_timeout(o_timer_timeout));
`default_nettype wire

// file: verif/gtil_global_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gtil_global_config_tb;
  localparam logic [7:0] CMD = gtil_pkg::ADDR_TMR_CMD;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic [7:0]  addr = 8'h80;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic        xtal_en = 1'b0;
  logic        ext_en = 1'b0;
  logic [7:0]  rx = 8'h00, ls = 8'h00, to = 8'h00, tx = 8'h00, md = 8'h00;
  logic [7:0]  rdata, flags, d;
  logic [15:0] rate;
  logic        xtal, ext, irq, tout;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n;
  logic [3:0]  rsv [5] = '{4'h0, 4'h7, 4'h8, 4'hc, 4'hf};
  always #20 i_clk = ~i_clk;
  gtil_tick_model tick_u (.i_clk(i_clk), .i_xtal_en(xtal_en),
    .i_ext_en(ext_en), .o_xtal_tick(xtal), .o_ext_clk(ext));
  gtil_global_config dut_u (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
    .i_xtal_tick(xtal), .i_timer_ext_clock_pin(ext),
    .i_receive_ready_int(rx), .i_line_status_int(ls),
    .i_rx_timeout_int(to), .i_transmit_ready_int(tx), .i_modem_int(md),
    .o_channel_summary_flags(flags), .o_sample_rate(rate), .o_irq(irq),
    .o_timer_timeout(tout));
  task automatic results;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
    @(negedge i_clk);
  endtask : wr_reg
  task automatic cmd(input logic [3:0] c);
    wr_reg(CMD, {4'h0, c});
  endtask : cmd
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(negedge i_clk);
    d = rdata;
    @(posedge i_clk);
    rd <= 1'b0;
    chk(d, e);
  endtask : rd_chk
  // Counts cycles up to the next time-out pulse, or to the limit.
  task automatic gap(input int lim, output int c);
    c = 0;
    do
    begin
      @(negedge i_clk);
      c++;
    end
    while (tout !== 1'b1 && c < lim);
  endtask : gap
  initial
  begin
    #800000;
    n_errors++;
    results();
  end
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (int a = 8'h80; a <= 8'h89; a++)
      rd_chk(a[7:0], 8'h00);
    rd_chk(8'h8f, 8'h00);
    wr_reg(gtil_pkg::ADDR_RELOAD_LO, 8'h03);
    wr_reg(gtil_pkg::ADDR_RELOAD_HI, 8'h01);
    wr_reg(gtil_pkg::ADDR_X8_SEL, 8'h05);
    wr_reg(gtil_pkg::ADDR_X4_SEL, 8'h0c);
    wr_reg(gtil_pkg::ADDR_SPARE, 8'hff);
    chk(rate, 16'h0081);
    rd_chk(gtil_pkg::ADDR_SPARE, 8'h00);
    rd_chk(gtil_pkg::ADDR_RELOAD_HI, 8'h01);
    rd_chk(gtil_pkg::ADDR_X4_SEL, 8'h0c);
    foreach (rsv[i])
      cmd(rsv[i]);
    @(posedge i_clk);
    xtal_en <= 1'b1;
    gap(600, n);
    chk(n[15:0], 16'd600);
    wr_reg(CMD, {4'hf, gtil_pkg::CMD_INT_EN});
    cmd(gtil_pkg::CMD_START);
    gap(2000, n);
    gap(2000, n);
    chk(n[15:0], 16'h0103);
    cmd(gtil_pkg::CMD_STOP);
    rd_chk(gtil_pkg::ADDR_SRC_A, {5'h00, gtil_pkg::SRC_TIMER});
    chk(irq, 1'b1);
    cmd(gtil_pkg::CMD_INT_DIS);
    chk(irq, 1'b0);
    rd_chk(CMD, gtil_pkg::STAT_PENDING);
    rd_chk(CMD, gtil_pkg::STAT_IDLE);
    cmd(gtil_pkg::CMD_ONESHOT);
    cmd(gtil_pkg::CMD_START);
    gap(600, n);
    chk(tout, 1'b1);
    gap(600, n);
    chk(n[15:0], 16'd600);
    @(posedge i_clk);
    xtal_en <= 1'b0;
    ext_en <= 1'b1;
    cmd(gtil_pkg::CMD_SRC_EXT);
    cmd(gtil_pkg::CMD_PERIODIC);
    cmd(gtil_pkg::CMD_START);
    gap(5000, n);
    gap(5000, n);
    chk(n[15:0], 16'h0818);
    cmd(gtil_pkg::CMD_RESET);
    gap(600, n);
    chk(n[15:0], 16'd600);
    cmd(gtil_pkg::CMD_SRC_XTAL);
    rd_chk(CMD, gtil_pkg::STAT_PENDING);
    @(posedge i_clk);
    to <= 8'h02;
    tx <= 8'h02;
    ls <= 8'h08;
    md <= 8'h80;
    rx <= 8'h01;
    rd_chk(gtil_pkg::ADDR_SRC_A, 8'h11);
    rd_chk(gtil_pkg::ADDR_SRC_B, 8'h02);
    rd_chk(gtil_pkg::ADDR_SRC_C, 8'h80);
    rd_chk(gtil_pkg::ADDR_SUMMARY, 8'h8b);
    results();
  end
endmodule : gtil_global_config_tb
`default_nettype wire
